//--- logic/mem_access_gate.sv
// Display buffer access gate: wakes the memory controller per write in power save, refuses reads there
`timescale 1ns/1ps
module mem_access_gate
    import power_save_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic power_save,
    input wire logic req_write,
    input wire logic req_read,
    output logic mem_enable,
    output logic mem_strobe,
    output logic done,
    output logic refused
);
    mem_state_t state_r;
    mem_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            MEM_IDLE: begin
                // Reads are refused while asleep; writes wake the controller
                if (req_write || (req_read && !power_save)) begin
                    state_nxt = MEM_WAKE;
                end
            end
            MEM_WAKE: state_nxt = MEM_BUSY;
            MEM_BUSY: state_nxt = MEM_IDLE;
            default: state_nxt = MEM_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= MEM_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Controller stays powered in normal mode, only per write in power save
    assign mem_enable = !power_save || (state_r != MEM_IDLE); // see [R03] see [R04]
    assign mem_strobe = (state_r == MEM_BUSY);
    assign done = (state_r == MEM_BUSY);
    assign refused = (state_r == MEM_IDLE) && req_read && power_save; // see [R12]
endmodule

//--- logic/power_save_ctrl.sv
// Software power save controller with Avalon-MM register slave
// What this block does
// [R01] Power save is active while bit 4 of the register at 0x14 is set and ends when cleared.
// [R02] Power save stops refresh reads, reports the display inactive and stops the PWM clock.
// [R03] Power save powers down the memory controller and shows its state in bit 6 of 0x14.
// [R04] Display buffer writes still complete in power save by waking the controller per write.
// [R05] Lookup table registers stay readable and writable in both modes.
// [R06] In power save the USB function is halted and its registers are not accessible.
// [R07] In power save panel outputs, including panel-assigned GPIO pins, are forced low.
// [R08] GPIO pins stay accessible in power save and outputs of pins not assigned to the panel follow host writes.
// [R09] Every reset leaves power save active with the enable bit set.
// [R10] The host programs configuration first and only then clears the power save bit.
// [R11] General register access works in both power save and normal mode.
// [R12] Display buffer reads are refused in power save and served normally otherwise.
`timescale 1ns/1ps
module power_save_ctrl
    import power_save_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic mem_read_req,
    input wire logic mem_write_req,
    output logic mem_read_done,
    output logic mem_write_done,
    output logic mem_read_refused,
    output logic mem_ctrl_enable,
    output logic mem_strobe,
    output logic refresh_enable,
    output logic display_active,
    output logic pwm_clock_out,
    output logic [PANEL_W-1:0] panel_out,
    output logic usb_run,
    input wire logic usb_reg_req,
    output logic usb_reg_grant,
    input wire logic [GPIO_W-1:0] gpio_in,
    output logic [GPIO_W-1:0] gpio_out,
    output logic [GPIO_W-1:0] gpio_oe
);
    logic ps_en_r;
    logic ps_en_nxt;
    logic [GPIO_W-1:0] gpio_dir_r;
    logic [GPIO_W-1:0] gpio_dir_nxt;
    logic [GPIO_W-1:0] gpio_val_r;
    logic [GPIO_W-1:0] gpio_val_nxt;
    logic [GPIO_W-1:0] panel_sel_r;
    logic [GPIO_W-1:0] panel_sel_nxt;
    logic [PANEL_W-1:0] panel_data_r;
    logic [PANEL_W-1:0] panel_data_nxt;
    logic [DATA_W-1:0] lut_r [LUT_DEPTH];
    logic [DATA_W-1:0] lut_nxt [LUT_DEPTH];
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic ack_r;
    logic ack_nxt;
    logic [PWM_DIV_W-1:0] pwm_cnt_r;
    logic [PWM_DIV_W-1:0] pwm_cnt_nxt;
    logic pwm_r;
    logic pwm_nxt;
    logic [PANEL_W-1:0] panel_r;
    logic [PANEL_W-1:0] panel_nxt;
    logic [GPIO_W-1:0] gpio_o_r;
    logic [GPIO_W-1:0] gpio_o_nxt;
    logic [GPIO_W-1:0] gpio_s1_r;
    logic [GPIO_W-1:0] gpio_s2_r;
    logic mem_en_w;
    logic lut_hit;
    logic [LUT_IDX_W-1:0] lut_idx;

    // Merge a bus write into an old word under the byte enables
    function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old_w,
                                                     input logic [DATA_W-1:0] new_w,
                                                     input logic [3:0] be);
        logic [DATA_W-1:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction

    mem_access_gate u_gate (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .power_save(ps_en_r),
        .req_write(mem_write_req),
        .req_read(mem_read_req),
        .mem_enable(mem_en_w),
        .mem_strobe(mem_strobe),
        .done(mem_write_done),
        .refused(mem_read_refused)
    );
    // Same gate answers both kinds; a read done is a done while not asleep and with no write request pending
    assign mem_ctrl_enable = mem_en_w;
    assign mem_read_done = mem_write_done && !ps_en_r && !mem_write_req;

    assign lut_hit = (avs_address >= OFS_LUT_BASE)
                     && (avs_address < OFS_LUT_BASE + ADDR_W'(LUT_DEPTH * 4));
    assign lut_idx = LUT_IDX_W'((avs_address - OFS_LUT_BASE) >> 2);

    // Register file: accessible in both modes
    always_comb begin
        ps_en_nxt = ps_en_r;
        gpio_dir_nxt = gpio_dir_r;
        gpio_val_nxt = gpio_val_r;
        panel_sel_nxt = panel_sel_r;
        panel_data_nxt = panel_data_r;
        rdata_nxt = rdata_r;
        for (int i = 0; i < LUT_DEPTH; i++) begin
            lut_nxt[i] = lut_r[i];
        end
        ack_nxt = 1'b0;
        if (avs_read || avs_write) begin // see [R11]
            ack_nxt = !ack_r;
            // A write lands only at the edge where waitrequest is low
            if (avs_write && ack_r) begin
                if (avs_address == OFS_PWR_SAVE && avs_byteenable[0]) begin
                    ps_en_nxt = avs_writedata[BIT_PS_EN]; // see [R01]
                end else if (avs_address == OFS_GPIO_DIR) begin
                    gpio_dir_nxt = GPIO_W'(merge_bytes(ZERO_WORD | gpio_dir_r,
                                                       avs_writedata, avs_byteenable));
                end else if (avs_address == OFS_GPIO_OUT) begin
                    gpio_val_nxt = GPIO_W'(merge_bytes(ZERO_WORD | gpio_val_r,
                                                       avs_writedata, avs_byteenable)); // see [R08]
                end else if (avs_address == OFS_PANEL_CFG) begin
                    panel_sel_nxt = GPIO_W'(merge_bytes(ZERO_WORD | panel_sel_r,
                                                        avs_writedata, avs_byteenable));
                    if (avs_byteenable[1]) begin
                        panel_data_nxt = avs_writedata[15:8];
                    end
                end else if (lut_hit) begin
                    lut_nxt[lut_idx] = merge_bytes(lut_r[lut_idx], avs_writedata,
                                                   avs_byteenable); // see [R05]
                end
            end else if (avs_read && !ack_r) begin
                rdata_nxt = UNMAPPED_DATA;
                if (avs_address == OFS_PWR_SAVE) begin
                    rdata_nxt[BIT_PS_EN] = ps_en_r;
                    rdata_nxt[BIT_MC_PS] = !mem_en_w; // see [R03]
                end else if (avs_address == OFS_GPIO_DIR) begin
                    rdata_nxt[GPIO_W-1:0] = gpio_dir_r;
                end else if (avs_address == OFS_GPIO_OUT) begin
                    rdata_nxt[GPIO_W-1:0] = gpio_s2_r; // see [R08]
                end else if (avs_address == OFS_PANEL_CFG) begin
                    rdata_nxt[GPIO_W-1:0] = panel_sel_r;
                    rdata_nxt[15:8] = panel_data_r;
                end else if (lut_hit) begin
                    rdata_nxt = lut_r[lut_idx]; // see [R05]
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ps_en_r <= 1'b1; // see [R09]
            gpio_dir_r <= '0;
            gpio_val_r <= '0;
            panel_sel_r <= '0;
            panel_data_r <= '0;
            rdata_r <= '0;
            ack_r <= 1'b0;
            for (int i = 0; i < LUT_DEPTH; i++) begin
                lut_r[i] <= '0;
            end
        end else begin
            ps_en_r <= ps_en_nxt;
            gpio_dir_r <= gpio_dir_nxt;
            gpio_val_r <= gpio_val_nxt;
            panel_sel_r <= panel_sel_nxt;
            panel_data_r <= panel_data_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
            for (int i = 0; i < LUT_DEPTH; i++) begin
                lut_r[i] <= lut_nxt[i];
            end
        end
    end

    // One wait cycle, then the answer in the second cycle
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
    assign avs_readdata = rdata_r;

    // Outputs that depend on power save
    always_comb begin
        pwm_cnt_nxt = pwm_cnt_r + PWM_DIV_W'(1);
        pwm_nxt = pwm_r;
        if (pwm_cnt_r == PWM_DIV_LAST) begin
            pwm_cnt_nxt = '0;
            pwm_nxt = !pwm_r;
        end
        if (ps_en_r) begin
            pwm_cnt_nxt = '0;
            pwm_nxt = 1'b0; // see [R02]
        end
        panel_nxt = ps_en_r ? '0 : panel_data_r; // see [R07]
        // Panel-assigned GPIO pins are forced low in power save; plain GPIO follows the host
        gpio_o_nxt = gpio_val_r & ~(panel_sel_r & {GPIO_W{ps_en_r}}); // see [R07] see [R08]
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwm_cnt_r <= '0;
            pwm_r <= 1'b0;
            panel_r <= '0;
            gpio_o_r <= '0;
            gpio_s1_r <= '0;
            gpio_s2_r <= '0;
        end else begin
            pwm_cnt_r <= pwm_cnt_nxt;
            pwm_r <= pwm_nxt;
            panel_r <= panel_nxt;
            gpio_o_r <= gpio_o_nxt;
            gpio_s1_r <= gpio_in;
            gpio_s2_r <= gpio_s1_r;
        end
    end

    assign pwm_clock_out = pwm_r;
    assign panel_out = panel_r;
    assign gpio_out = gpio_o_r;
    assign gpio_oe = gpio_dir_r | panel_sel_r;
    assign refresh_enable = !ps_en_r; // see [R02]
    assign display_active = !ps_en_r; // see [R02]
    assign usb_run = !ps_en_r; // see [R06]
    assign usb_reg_grant = usb_reg_req && !ps_en_r; // see [R06]

    a_pwm_stopped: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R02]
        ps_en_r |=> !pwm_clock_out)
        else $error("PWM clock runs in power save");
    a_panel_low: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R07]
        ps_en_r && $past(ps_en_r) |-> panel_out == '0)
        else $error("Panel outputs not low in power save");
    a_ps_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R01]
        avs_write && !avs_waitrequest && avs_address == OFS_PWR_SAVE && avs_byteenable[0]
        |=> ps_en_r == $past(avs_writedata[BIT_PS_EN]))
        else $error("Power save bit did not follow write");
    a_usb_grant: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R06]
        ps_en_r |-> !usb_reg_grant && !usb_run)
        else $error("USB active in power save");
    a_mc_status: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R03]
        !ps_en_r |-> mem_ctrl_enable)
        else $error("Memory controller off in normal mode");
    a_write_done: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R04]
        u_gate.state_r == MEM_IDLE && mem_write_req |-> ##2 mem_write_done)
        else $error("Buffer write did not complete");
    a_read_refused: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R12]
        ps_en_r && mem_read_req && !mem_write_req && u_gate.state_r == MEM_IDLE
        |-> mem_read_refused ##1 !mem_strobe)
        else $error("Buffer read served in power save");
    a_bus_answer: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R11]
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("Bus answer late");
    a_reset_ps: assert property (@(posedge ref_clk) // see [R09]
        $rose(rst_n) |-> ps_en_r)
        else $error("Power save not set after reset");
endmodule

//--- shared/power_save_pkg.sv
// Constants shared by the power save controller and its access gate
package power_save_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_PWR_SAVE = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_GPIO_DIR = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_GPIO_OUT = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_PANEL_CFG = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_LUT_BASE = 8'h80;
    localparam int LUT_DEPTH = 16;
    localparam int LUT_IDX_W = 4;
    localparam int BIT_PS_EN = 4;
    localparam int BIT_MC_PS = 6;
    localparam int GPIO_W = 8;
    localparam int PANEL_W = 8;
    localparam int PWM_DIV_W = 4;
    localparam logic [PWM_DIV_W-1:0] PWM_DIV_LAST = 4'h3;
    localparam logic [DATA_W-1:0] UNMAPPED_DATA = 32'h0000_0000;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
    typedef enum logic [1:0] {
        MEM_IDLE,
        MEM_WAKE,
        MEM_BUSY
    } mem_state_t;
endpackage

//--- testbench/host_bus_model.sv
// Host processor model: Avalon-MM master issuing single register accesses
`timescale 1ns/1ps
module host_bus_model
    import power_save_pkg::*;
(
    input wire logic ref_clk,
    output logic [ADDR_W-1:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [DATA_W-1:0] avs_writedata,
    output logic [3:0] avs_byteenable,
    input wire logic [DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    output logic hung
);
    initial begin
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = 4'h0;
        hung = 1'b0;
    end
    // Request held until waitrequest is sampled low; only the bench watchdog ends a wait
    task automatic access(input logic wr, input logic [ADDR_W-1:0] addr,
                          input logic [DATA_W-1:0] wdata, output logic [DATA_W-1:0] rdata);
        @(posedge ref_clk);
        avs_address <= addr;
        avs_writedata <= wdata;
        avs_read <= ~wr;
        avs_write <= wr;
        avs_byteenable <= 4'hF;
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        // Unknown read data at the answering edge counts against the run
        if (!wr && $isunknown(avs_readdata)) hung = 1'b1;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // A released data bus shows the inverse, so stale data never looks valid
        avs_writedata <= ~wdata;
    endtask
endmodule

//--- testbench/software_power_save_control_test.sv
// Self-checking bench for the software power save controller
`timescale 1ns/1ps
module software_power_save_control_test import power_save_pkg::*;;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] m; logic [31:0] e;} row_t;
    logic ref_clk, rst_n, wr, rd, mem_read_req, mem_write_req, waitreq, hung;
    logic mem_read_done, mem_write_done, mem_read_refused, mem_ctrl_enable, mem_strobe;
    logic refresh_enable, display_active, pwm_clock_out, usb_run, usb_reg_req, usb_reg_grant;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, got;
    logic [3:0] be;
    logic [7:0] panel_out, gpio_in, gpio_out, gpio_oe;
    logic fin, en, refd;
    int fails, num_checks, n;
    row_t rows[5] = '{'{8'h80, 32'hA5A5_0001, 32'hFFFF_FFFF, 32'hA5A5_0001},
        '{8'hBC, 32'h0000_3C3C, 32'hFFFF_FFFF, 32'h0000_3C3C},
        '{8'h18, 32'h0000_00F0, 32'h0000_00FF, 32'h0000_00F0},
        '{8'h40, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_0000},
        '{8'h1C, 32'h0000_0033, 32'h0000_00FF, 32'h0000_005A}};
    host_bus_model u_host (.ref_clk(ref_clk), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(waitreq), .hung(hung));
    power_save_ctrl u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(addr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be),
        .avs_readdata(rdata), .avs_waitrequest(waitreq), .mem_read_req(mem_read_req),
        .mem_write_req(mem_write_req), .mem_read_done(mem_read_done),
        .mem_write_done(mem_write_done), .mem_read_refused(mem_read_refused),
        .mem_ctrl_enable(mem_ctrl_enable), .mem_strobe(mem_strobe),
        .refresh_enable(refresh_enable), .display_active(display_active),
        .pwm_clock_out(pwm_clock_out), .panel_out(panel_out), .usb_run(usb_run),
        .usb_reg_req(usb_reg_req), .usb_reg_grant(usb_reg_grant), .gpio_in(gpio_in),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic check_word(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic check_flag(input logic g, input logic e);
        check_word({31'h0, g}, {31'h0, e});
    endtask
    task automatic mem_access(input logic w);
        fin = 1'b0;
        en = 1'b0;
        refd = 1'b0;
        @(posedge ref_clk);
        if (w) mem_write_req <= 1'b1;
        else mem_read_req <= 1'b1;
        for (int i = 0; i < 8 && !fin && !refd; i++) begin
            @(posedge ref_clk);
            en = en | (mem_ctrl_enable === 1'b1);
            refd = (mem_read_refused === 1'b1);
            fin = ((w ? mem_write_done : mem_read_done) === 1'b1);
        end
        mem_write_req <= 1'b0;
        mem_read_req <= 1'b0;
    endtask
    // Counts level changes of the PWM output over 16 clocks
    task automatic pwm_toggles();
        logic prev;
        n = 0;
        @(posedge ref_clk);
        prev = pwm_clock_out;
        repeat (16) begin
            @(posedge ref_clk);
            if (pwm_clock_out !== prev) n++;
            prev = pwm_clock_out;
        end
    endtask
    task automatic check_mode(input logic ps);
        check_flag(refresh_enable, !ps);
        check_flag(display_active, !ps);
        check_flag(usb_run, !ps);
        check_flag(usb_reg_grant, !ps);
        check_word({24'h0, panel_out}, ps ? 32'h0 : 32'h0000_00C3);
        pwm_toggles();
        check_word(n, ps ? 32'h0 : 32'h4);
    endtask
    task automatic tally_and_finish();
        if (hung) fails++;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        tally_and_finish();
    end
    initial begin
        rst_n = 1'b0;
        mem_read_req = 1'b0;
        mem_write_req = 1'b0;
        usb_reg_req = 1'b0;
        gpio_in = 8'h5A;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        usb_reg_req <= 1'b1;
        u_host.access(1'b0, OFS_PWR_SAVE, 32'h0, got);
        check_word(got & 32'h50, 32'h0000_0050);
        check_flag(mem_ctrl_enable, 1'b0);
        check_mode(1'b1);
        $display("test reset done");
        foreach (rows[i]) begin
            u_host.access(1'b1, rows[i].a, rows[i].w, got);
            u_host.access(1'b0, rows[i].a, 32'h0, got);
            check_word(got & rows[i].m, rows[i].e);
        end
        $display("test table done");
        // Configuration goes in before power save is lifted
        u_host.access(1'b1, OFS_PANEL_CFG, 32'h0000_C301, got);
        repeat (2) @(posedge ref_clk);
        check_word({24'h0, gpio_out}, 32'h0000_0032);
        check_word({24'h0, gpio_oe}, 32'h0000_00F1);
        mem_access(1'b1);
        check_flag(fin & en, 1'b1);
        mem_access(1'b0);
        check_flag(refd & !fin, 1'b1);
        $display("test power save access done");
        u_host.access(1'b1, OFS_PWR_SAVE, 32'h0, got);
        u_host.access(1'b0, OFS_PWR_SAVE, 32'h0, got);
        check_word(got & 32'h50, 32'h0);
        check_mode(1'b0);
        mem_access(1'b0);
        check_flag(fin & !refd, 1'b1);
        $display("test normal mode done");
        u_host.access(1'b1, OFS_PWR_SAVE, 32'h0000_0010, got);
        u_host.access(1'b0, OFS_PWR_SAVE, 32'h0, got);
        check_word(got & 32'h50, 32'h0000_0050);
        check_mode(1'b1);
        $display("test re-entry done");
        tally_and_finish();
    end
endmodule
